// file: sfr_pkg.sv
/*
  Shared constants and types for the serial flash read and identification engine.
  Assumes nothing beyond a SystemVerilog-2012 compiler.
*/
`default_nettype none

package sfr_pkg;

  // ----------------------------------------
  // command codes, sent most significant bit first
  // ----------------------------------------
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST = 8'h0B;
  localparam logic [7:0] OPC_DUAL = 8'hBB;
  localparam logic [7:0] OPC_QUAD = 8'hEB;
  localparam logic [7:0] OPC_DEVID = 8'h9F;
  localparam logic [7:0] OPC_SIID = 8'hAB;
  localparam logic [7:0] OPC_WREN = 8'h06;

  // ----------------------------------------
  // frame geometry
  // ----------------------------------------
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] OPC_LAST = 5'h07;
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned MEM_AW = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DUMMY_FAST = 8;
  localparam int unsigned DUMMY_DUAL = 4;
  localparam int unsigned DUMMY_QUAD = 6;
  localparam int unsigned DUMMY_DEVID = 2;
  localparam int unsigned SIID_DUMMY_BYTES = 3;

  // ----------------------------------------
  // clocks: system clock and host serial clock limits
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned READ_SCLK_MAX_MHZ = 50;
  localparam int unsigned FAST_SCLK_MAX_MHZ = 100;

  typedef enum logic [2:0] {
    ST_OPC = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DATA = 3'h2,
    ST_SINK = 3'h6
  } sfr_state_t;

  typedef enum logic [2:0] {
    MD_READ = 3'h0,
    MD_FAST = 3'h1,
    MD_DUAL = 3'h2,
    MD_QUAD = 3'h3,
    MD_DEVID = 3'h4,
    MD_SIID = 3'h5
  } sfr_mode_t;

endpackage : sfr_pkg

`default_nettype wire

// file: sfr_mem_if.sv
/*
  Bundle between the engine and its byte array: a load port on the system clock
  and an asynchronous read port used on the serial clock.
  Assumes sfr_pkg is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

interface sfr_mem_if;
  import sfr_pkg::*;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [MEM_AW-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : sfr_mem_if

`default_nettype wire

// file: sfr_sync.sv
/*
  Two flip-flop level synchroniser, W bits wide.
  Assumes each bit changes independently (levels or toggles only).
*/
`timescale 1ns/100ps
`default_nettype none

module sfr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : sfr_sync

`default_nettype wire

// file: sfr_mem.sv
/*
  Byte array of the flash: written on the system clock, read asynchronously.
  Assumes nobody reads a location in the same period that it is loaded.
*/
`timescale 1ns/100ps
`default_nettype none

module sfr_mem
  import sfr_pkg::*;
(
  input wire logic clk,
  sfr_mem_if.store mem
);

  logic [DATA_W-1:0] array_reg [0:(1<<MEM_AW)-1];

  always_ff @(posedge clk)
  begin
    if (mem.wr_en)
    begin
      array_reg[mem.wr_addr] <= mem.wr_data;
    end
  end

  assign mem.rd_data = array_reg[mem.rd_addr];

endmodule : sfr_mem

`default_nettype wire

// file: sfr_flash_top.sv
/*
  Command engine of a serial configuration flash: plain, fast, dual and quad
  reads, device and silicon identification, and write enable.
  Assumes the host drives select and serial clock as an SPI master, mode 0,
  and that prog_busy and wel_clear come from logic on clk.
*/
// Behaviour
// - read 03h, three address bytes on rising edges
// - read data MSB first on line one
// - output bits change on falling edges
// - address advances after every byte
// - address wraps to zero, streams until deselect
// - plain read ignored while busy
// - fast read adds 8 dummy clocks
// - fast read data on falling edges, 100 MHz
// - deselect stops output drive at once
// - fast reads ignored while busy
// - BBh moves address and data two lines
// - dual read has 4 dummy clocks
// - EBh moves address and data four lines
// - quad read has 6 dummy clocks
// - 9Fh returns 8-bit device code
// - device code request ignored while busy
// - ABh, three dummy bytes, then silicon code
// - silicon code repeats until deselect
// - silicon code request ignored while busy
// - 06h sets write enable latch
`timescale 1ns/100ps
`default_nettype none

module sfr_flash_top
  import sfr_pkg::*;
#(
  // identity codes: arbitrary neutral values
  parameter logic [7:0] DEV_ID = 8'h5A,
  parameter logic [7:0] SI_ID = 8'hA5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic select_bar_pin,
  input wire logic serial_clock_pin,
  input wire logic io_line_zero_in,
  input wire logic io_line_one_in,
  input wire logic io_line_two_in,
  input wire logic io_line_three_in,
  output logic io_line_zero_out,
  output logic io_line_one_out,
  output logic io_line_two_out,
  output logic io_line_three_out,
  output logic io_line_zero_oe,
  output logic io_line_one_oe,
  output logic io_line_two_oe,
  output logic io_line_three_oe,
  input wire logic prog_busy,
  input wire logic wel_clear,
  output logic wel_out,
  input wire logic load_en,
  input wire logic [MEM_AW-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_data
);

  // ----------------------------------------
  // per-mode geometry
  // ----------------------------------------
  function automatic logic [2:0] lanes_of(input sfr_mode_t m);
    unique case (m)
      MD_DUAL: lanes_of = 3'h2;
      MD_QUAD: lanes_of = 3'h4;
      default: lanes_of = 3'h1;
    endcase
  endfunction : lanes_of

  function automatic logic [CNT_W-1:0] addr_last(input sfr_mode_t m);
    unique case (m)
      MD_DUAL: addr_last = CNT_W'(ADDR_BITS / 2 - 1);
      MD_QUAD: addr_last = CNT_W'(ADDR_BITS / 4 - 1);
      MD_SIID: addr_last = CNT_W'(SIID_DUMMY_BYTES * 8 - 1);
      default: addr_last = CNT_W'(ADDR_BITS - 1);
    endcase
  endfunction : addr_last

  function automatic logic [CNT_W-1:0] dummy_cnt(input sfr_mode_t m);
    unique case (m)
      MD_FAST: dummy_cnt = CNT_W'(DUMMY_FAST);
      MD_DUAL: dummy_cnt = CNT_W'(DUMMY_DUAL);
      MD_QUAD: dummy_cnt = CNT_W'(DUMMY_QUAD);
      MD_DEVID: dummy_cnt = CNT_W'(DUMMY_DEVID);
      default: dummy_cnt = '0;
    endcase
  endfunction : dummy_cnt

  function automatic logic [CNT_W-1:0] byte_last(input sfr_mode_t m);
    byte_last = CNT_W'(DATA_W / lanes_of(m) - 1);
  endfunction : byte_last

  // ----------------------------------------
  // link reset and inputs
  // ----------------------------------------
  // raising select clears every link flop but the busy sync and write enable toggle at once; the serial clock may be
  // stopped outside a frame, so no clocked clean-up could be relied upon
  logic link_rst_n;
  logic busy_link;
  logic [3:0] io_in;
  sfr_mem_if mem_bus ();

  assign link_rst_n = nrst & ~select_bar_pin;
  assign io_in = {io_line_three_in, io_line_two_in, io_line_one_in, io_line_zero_in};

  // busy only needs to be settled by the sixth opcode edge, two sync edges before the decision on the eighth
  sfr_sync #(
    .W(1)
  ) u_busy_sync (
    .clk(serial_clock_pin),
    .nrst(nrst),
    .d(prog_busy),
    .q(busy_link)
  );

  sfr_mem u_mem (
    .clk(clk),
    .mem(mem_bus.store)
  );

  // ----------------------------------------
  // opcode capture and decode
  // ----------------------------------------
  sfr_state_t state_reg;
  sfr_mode_t mode_reg;
  sfr_mode_t dec_mode;
  logic dec_ok;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0] opc_reg;
  logic [7:0] opc_word;
  logic opc_done;
  logic [MEM_AW-1:0] addr_reg;
  logic wel_tgl_reg;
  logic [2:0] lanes;
  logic [CNT_W-1:0] last_idx;

  assign opc_word = {opc_reg[6:0], io_in[0]};
  assign last_idx = byte_last(mode_reg);
  assign opc_done = (state_reg == ST_OPC) && (cnt_reg == OPC_LAST);
  assign lanes = lanes_of(mode_reg);

  always_comb
  begin
    dec_ok = 1'b1;
    dec_mode = MD_READ;
    unique case (opc_word)
      OPC_READ: dec_mode = MD_READ;
      OPC_FAST: dec_mode = MD_FAST;
      OPC_DUAL: dec_mode = MD_DUAL;
      OPC_QUAD: dec_mode = MD_QUAD;
      OPC_DEVID: dec_mode = MD_DEVID;
      OPC_SIID: dec_mode = MD_SIID;
      default: dec_ok = 1'b0;
    endcase
  end

  always_ff @(posedge serial_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      opc_reg <= 8'h00;
    end
    else if (state_reg == ST_OPC)
    begin
      opc_reg <= opc_word;
    end
  end

  always_ff @(posedge serial_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      mode_reg <= MD_READ;
    end
    else if (opc_done)
    begin
      mode_reg <= dec_mode;
    end
  end

  // ----------------------------------------
  // frame sequencer, rising edges
  // ----------------------------------------
  always_ff @(posedge serial_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_reg <= ST_OPC;
      cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_OPC:
        begin
          cnt_reg <= opc_done ? '0 : cnt_reg + 1'b1;
          if (opc_done)
          begin
            // a busy device drops the frame and leaves the running cycle alone
            if (!dec_ok || busy_link)
            begin
              state_reg <= ST_SINK;
            end
            else if (dec_mode == MD_DEVID)
            begin
              state_reg <= ST_DUMMY;
            end
            else
            begin
              state_reg <= ST_ADDR;
            end
          end
        end
        ST_ADDR:
        begin
          if (cnt_reg == addr_last(mode_reg))
          begin
            cnt_reg <= '0;
            state_reg <= (dummy_cnt(mode_reg) == '0) ? ST_DATA : ST_DUMMY;
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_DUMMY:
        begin
          if (cnt_reg == dummy_cnt(mode_reg) - 1'b1)
          begin
            cnt_reg <= '0;
            state_reg <= ST_DATA;
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_DATA:
        begin
          if (cnt_reg == byte_last(mode_reg))
          begin
            cnt_reg <= '0;
            // the device code goes out once; the silicon code repeats
            if (mode_reg == MD_DEVID)
            begin
              state_reg <= ST_SINK;
            end
          end
          else
          begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_SINK:
        begin
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // address register
  // ----------------------------------------
  // upper address bits beyond the array are dropped, so the count wraps at
  // the top of the array
  always_ff @(posedge serial_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      addr_reg <= '0;
    end
    else if (state_reg == ST_ADDR)
    begin
      unique case (lanes)
        3'h2: addr_reg <= {addr_reg[MEM_AW-3:0], io_in[1:0]};
        3'h4: addr_reg <= {addr_reg[MEM_AW-5:0], io_in};
        default: addr_reg <= {addr_reg[MEM_AW-2:0], io_in[0]};
      endcase
    end
    else if (state_reg == ST_DATA && cnt_reg == byte_last(mode_reg))
    begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // toggle survives deselect; only the system side reads it, through sync
  always_ff @(posedge serial_clock_pin or negedge nrst)
  begin
    if (!nrst)
    begin
      wel_tgl_reg <= 1'b0;
    end
    else if (!select_bar_pin && opc_done && opc_word == OPC_WREN)
    begin
      wel_tgl_reg <= ~wel_tgl_reg;
    end
  end

  // ----------------------------------------
  // output shifter, falling edges
  // ----------------------------------------
  logic [DATA_W-1:0] src_byte;
  logic [DATA_W-1:0] cur_byte;
  logic [DATA_W-1:0] out_shift_reg;
  logic [2:0] out_cnt_reg;
  logic [3:0] io_out_reg;
  logic [3:0] io_oe_reg;

  assign mem_bus.rd_addr = addr_reg;

  always_comb
  begin
    unique case (mode_reg)
      MD_DEVID: src_byte = DEV_ID;
      MD_SIID: src_byte = SI_ID;
      default: src_byte = mem_bus.rd_data;
    endcase
  end

  assign cur_byte = (out_cnt_reg == 3'h0) ? src_byte : out_shift_reg;

  always_ff @(negedge serial_clock_pin or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      out_shift_reg <= 8'h00;
      out_cnt_reg <= 3'h0;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end
    else if (state_reg == ST_DATA)
    begin
      out_shift_reg <= cur_byte << lanes;
      out_cnt_reg <= (out_cnt_reg == 3'h0) ? last_idx[2:0] : out_cnt_reg - 3'h1;
      unique case (lanes)
        3'h2:
        begin
          io_out_reg <= {2'h0, cur_byte[7:6]};
          io_oe_reg <= 4'h3;
        end
        3'h4:
        begin
          io_out_reg <= cur_byte[7:4];
          io_oe_reg <= 4'hF;
        end
        default:
        begin
          io_out_reg <= {2'h0, cur_byte[7], 1'b0};
          io_oe_reg <= 4'h2;
        end
      endcase
    end
    else
    begin
      out_cnt_reg <= 3'h0;
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end
  end

  assign io_line_zero_out = io_out_reg[0];
  assign io_line_one_out = io_out_reg[1];
  assign io_line_two_out = io_out_reg[2];
  assign io_line_three_out = io_out_reg[3];
  assign io_line_zero_oe = io_oe_reg[0];
  assign io_line_one_oe = io_oe_reg[1];
  assign io_line_two_oe = io_oe_reg[2];
  assign io_line_three_oe = io_oe_reg[3];

  // ----------------------------------------
  // system side: array load and write enable latch
  // ----------------------------------------
  logic wel_tgl_sync;
  logic wel_tgl_seen_reg;
  logic wel_set;

  assign mem_bus.wr_en = load_en;
  assign mem_bus.wr_addr = load_addr;
  assign mem_bus.wr_data = load_data;

  sfr_sync #(
    .W(1)
  ) u_wel_sync (
    .clk(clk),
    .nrst(nrst),
    .d(wel_tgl_reg),
    .q(wel_tgl_sync)
  );

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wel_tgl_seen_reg <= 1'b0;
    end
    else
    begin
      wel_tgl_seen_reg <= wel_tgl_sync;
    end
  end

  assign wel_set = wel_tgl_sync ^ wel_tgl_seen_reg;

  // a set arriving with a clear wins, so no write enable is lost
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wel_out <= 1'b0;
    end
    else if (wel_set)
    begin
      wel_out <= 1'b1;
    end
    else if (wel_clear)
    begin
      wel_out <= 1'b0;
    end
  end

endmodule : sfr_flash_top

`default_nettype wire

// file: sfr_flash_top_assertions.sv
/* Checker for the flash command engine, bound to its top module.
   Assumes the host keeps select high between commands. */
`timescale 1ns/100ps
`default_nettype none
module sfr_flash_top_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic select_bar_pin,
  input wire logic serial_clock_pin,
  input wire logic io_line_one_out,
  input wire logic io_line_zero_oe,
  input wire logic io_line_one_oe,
  input wire logic io_line_two_oe,
  input wire logic io_line_three_oe,
  input wire logic prog_busy,
  input wire logic wel_clear,
  input wire logic wel_out
);
  logic any_oe;
  logic [5:0] rise_cnt_reg;
  logic busy_all_reg;
  assign any_oe = io_line_zero_oe | io_line_one_oe | io_line_two_oe | io_line_three_oe;
  // rises in this frame: no command drives before the tenth
  always_ff @(posedge serial_clock_pin or posedge select_bar_pin)
    if (select_bar_pin)
      rise_cnt_reg <= 6'h00;
    else if (rise_cnt_reg != 6'h3F)
      rise_cnt_reg <= rise_cnt_reg + 6'h01;
  // busy seen at every rise so far; short busy blips are not judged
  always_ff @(posedge serial_clock_pin or posedge select_bar_pin)
    if (select_bar_pin)
      busy_all_reg <= 1'b1;
    else
      busy_all_reg <= busy_all_reg & prog_busy;
  AST_DESEL_QUIET: assert property (@(posedge clk) disable iff (!nrst)
    select_bar_pin |-> !any_oe) else $error("drive while deselected");
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    $past(serial_clock_pin & ~select_bar_pin) && serial_clock_pin && !select_bar_pin
    |-> $stable(io_line_one_out)) else $error("data moved while clock high");
  AST_OE_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    $past(serial_clock_pin & ~select_bar_pin) && serial_clock_pin && !select_bar_pin
    |-> $stable(io_line_one_oe)) else $error("enable moved while clock high");
  AST_DUAL_PAIR: assert property (@(posedge clk) disable iff (!nrst)
    io_line_zero_oe |-> io_line_one_oe) else $error("line zero driven alone");
  AST_QUAD_SET: assert property (@(posedge clk) disable iff (!nrst)
    io_line_two_oe |-> io_line_zero_oe && io_line_three_oe) else $error("quad lanes split");
  AST_EARLY_QUIET: assert property (@(posedge serial_clock_pin)
    disable iff (!nrst || select_bar_pin) rise_cnt_reg < 6'h0A |-> !any_oe)
    else $error("drive before command complete");
  AST_BUSY_REFUSE: assert property (@(posedge serial_clock_pin)
    disable iff (!nrst || select_bar_pin) busy_all_reg |-> !any_oe)
    else $error("drive while busy");
  AST_WEL_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    $fell(wel_out) |-> $past(wel_clear) || $past(wel_clear, 2)) else $error("latch lost");
  cover property (@(posedge clk) io_line_three_oe);
  cover property (@(posedge clk) $rose(wel_out));
  cover property (@(posedge serial_clock_pin) busy_all_reg && rise_cnt_reg == 6'h20);
endmodule : sfr_flash_top_assertions
`default_nettype wire

// file: sfr_host_model.sv
/* Host model: drives select, serial clock and data lines of the flash.
   Assumes a 160 ns serial clock; merges its own and the device drivers. */
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model (
  output logic select_bar_pin,
  output logic serial_clock_pin,
  output wire logic [3:0] io_in,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  logic [3:0] hv = 4'h0;
  logic hd = 1'b0;
  logic saw_oe = 1'b0;
  logic [7:0] rx [$];
  logic [7:0] rx_raw [$];
  wire logic [3:0] take = dev_oe & ~{4{hd}};
  // released lines invert each cycle so stale values never pass
  assign io_in = (take & dev_out) | (~take & hv);
  initial select_bar_pin = 1'b1;
  initial serial_clock_pin = 1'b0;
  task automatic cyc(input logic [3:0] v, input logic drv, output logic [3:0] s);
    hv = drv ? v : ~hv;
    hd = drv;
    #80;
    serial_clock_pin = 1'b1;
    s = io_in;
    saw_oe = saw_oe | (|dev_oe);
    #80;
    serial_clock_pin = 1'b0;
  endtask : cyc
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int w,
                       input int dum, input int nb, input int dw);
    logic [3:0] s;
    logic [7:0] b;
    logic [7:0] raw;
    logic [23:0] sh;
    rx.delete();
    rx_raw.delete();
    saw_oe = 1'b0;
    sh = a;
    select_bar_pin = 1'b0;
    #37;
    for (int i = 7; i >= 0; i--) cyc({3'h0, op[i]}, 1'b1, s);
    for (int i = 0; w > 0 && i < 24 / w; i++)
    begin
      cyc(sh[23:20] >> (4 - w), 1'b1, s);
      sh = sh << w;
    end
    for (int i = 0; i < dum; i++) cyc(4'h0, 1'b0, s);
    for (int i = 0; i < nb * 8 / dw; i++)
    begin
      cyc(4'h0, 1'b0, s);
      b = (dw == 1) ? {b[6:0], s[1]} : (dw == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
      // raw image view: the same stream taken least significant bit first
      raw = {s[1], raw[7:1]};
      if ((i + 1) % (8 / dw) == 0)
      begin
        rx.push_back(b);
        rx_raw.push_back(raw);
      end
    end
    #43;
    select_bar_pin = 1'b1;
    hd = 1'b0;
    #200;
  endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// file: test_sfr_flash_top.sv
/* Bench for the flash command engine: host model on the link, loads, busy
   and write enable on the system clock. Assumes all other files compiled first. */
`timescale 1ns/100ps
`default_nettype none
module test_sfr_flash_top;
  import sfr_pkg::*;
  localparam logic [7:0] DEV_CODE = 8'h3C;  // arbitrary
  localparam logic [7:0] SI_CODE = 8'hC3;  // arbitrary
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic prog_busy = 1'b0;
  logic wel_clear = 1'b0;
  logic load_en = 1'b0;
  logic [MEM_AW-1:0] load_addr = '0;
  logic [DATA_W-1:0] load_data = '0;
  logic [7:0] mem [4096];
  logic [7:0] ops [6] = '{OPC_READ, OPC_FAST, OPC_DUAL, OPC_QUAD, OPC_DEVID, OPC_SIID};
  wire logic sel, sck, wel;
  wire logic [3:0] io_in, dout, doe;
  int n_errors = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  sfr_host_model h (.select_bar_pin(sel), .serial_clock_pin(sck), .io_in(io_in),
    .dev_out(dout), .dev_oe(doe));
  sfr_flash_top #(.DEV_ID(DEV_CODE), .SI_ID(SI_CODE)) DUT (.clk(clk), .nrst(nrst),
    .select_bar_pin(sel), .serial_clock_pin(sck), .io_line_zero_in(io_in[0]),
    .io_line_one_in(io_in[1]), .io_line_two_in(io_in[2]), .io_line_three_in(io_in[3]),
    .io_line_zero_out(dout[0]), .io_line_one_out(dout[1]), .io_line_two_out(dout[2]),
    .io_line_three_out(dout[3]), .io_line_zero_oe(doe[0]), .io_line_one_oe(doe[1]),
    .io_line_two_oe(doe[2]), .io_line_three_oe(doe[3]), .prog_busy(prog_busy),
    .wel_clear(wel_clear), .wel_out(wel), .load_en(load_en), .load_addr(load_addr),
    .load_data(load_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return mem[a[11:0]];
  endfunction : exp_byte
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction : rev8
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int w, input int dum,
                    input int dw);
    h.frame(op, a, w, dum, 3, dw);
    for (int i = 0; i < 3; i++) chk(h.rx[i], exp_byte(a + 24'(i)));
    if (dw == 1) chk(h.rx_raw[0], rev8(exp_byte(a)));
  endtask : rd
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(32618));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4096; i++)
    begin
      @(posedge clk);
      mem[i] = 8'($urandom);
      load_en <= 1'b1;
      load_addr <= 12'(i);
      load_data <= mem[i];
    end
    @(posedge clk);
    load_en <= 1'b0;
    rd(OPC_READ, 24'($urandom), 1, 0, 1);
    rd(OPC_READ, 24'h7A5FFE, 1, 0, 1);
    rd(OPC_FAST, 24'($urandom), 1, DUMMY_FAST, 1);
    rd(OPC_DUAL, 24'h000FFF, 2, DUMMY_DUAL, 2);
    rd(OPC_QUAD, 24'($urandom), 4, DUMMY_QUAD, 4);
    h.frame(OPC_READ, 24'h0, 0, 5, 0, 1);
    h.frame(OPC_DEVID, 24'h0, 0, DUMMY_DEVID, 1, 1);
    chk(h.rx[0], DEV_CODE);
    h.frame(OPC_SIID, 24'h0, 0, 24, 2, 1);
    chk(h.rx[0], SI_CODE);
    chk(h.rx[1], SI_CODE);
    @(posedge clk);
    prog_busy <= 1'b1;
    foreach (ops[k])
    begin
      h.frame(ops[k], 24'h0, 0, 40, 1, 1);
      chk({7'h00, h.saw_oe}, 8'h00);
    end
    h.frame(OPC_WREN, 24'h0, 0, 0, 0, 1);
    chk({7'h00, wel}, 8'h01);
    @(posedge clk);
    wel_clear <= 1'b1;
    prog_busy <= 1'b0;
    @(posedge clk);
    wel_clear <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({7'h00, wel}, 8'h00);
    rd(OPC_FAST, 24'($urandom), 1, DUMMY_FAST, 1);
    wrap_up();
  end
  initial
  begin
    #450000;
    n_errors++;
    wrap_up();
  end
endmodule : test_sfr_flash_top
bind sfr_flash_top sfr_flash_top_assertions u_chk (.clk(clk), .nrst(nrst),
  .select_bar_pin(select_bar_pin), .serial_clock_pin(serial_clock_pin),
  .io_line_one_out(io_line_one_out), .io_line_zero_oe(io_line_zero_oe),
  .io_line_one_oe(io_line_one_oe), .io_line_two_oe(io_line_two_oe),
  .io_line_three_oe(io_line_three_oe), .prog_busy(prog_busy), .wel_clear(wel_clear),
  .wel_out(wel_out));
`default_nettype wire
